// [core/rivp_pkg.sv]
// Constants and carrier types for reset and interrupt vector placement.
// Assumes one 20 MHz core clock; addresses are program words.
package rivp_pkg;
  localparam int          RIVP_NUM_VEC        = 26;
  localparam int          RIVP_NUM_IRQ        = 25;
  localparam int          RIVP_ADDR_W         = 13;
  localparam logic [12:0] RIVP_RESET_ADDR     = 13'h0000;
  localparam logic [12:0] RIVP_BOOT_START_2K  = 13'h0C00;
  localparam logic [12:0] RIVP_BOOT_START_DEF = 13'h1C00;
  localparam logic        RIVP_FUSE_PROG      = 1'b0;
  localparam logic [12:0] RIVP_WORDS_SMALL    = 13'h0001;
  localparam logic [12:0] RIVP_WORDS_LARGE    = 13'h0002;

  typedef enum logic [1:0] {
    RIVP_ST_RESET,
    RIVP_ST_IDLE,
    RIVP_ST_WAIT
  } rivp_state_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  vec_num;
    logic [12:0] addr;
  } rivp_fetch_t;
endpackage

// [core/rivp_vector.sv]
// Vector address generator: picks the reset entry and the pending interrupt entry.
// Assumes requests and the fetch acknowledge come from core logic on clk;
// the fuse level and the vector-select bit are steady core signals.
`timescale 1ns/1ps
module rivp_vector
  import rivp_pkg::*;
#(
  parameter bit          LARGE_VARIANT = 1'b1,
  parameter logic [12:0] BOOT_START    = rivp_pkg::RIVP_BOOT_START_DEF
)(
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        boot_reset_fuse,
  input  wire logic                        vector_select_bit,
  input  wire logic [rivp_pkg::RIVP_NUM_IRQ-1:0] irq_req,
  input  wire logic                        fetch_ack,
  output rivp_pkg::rivp_fetch_t            fetch_q
);
  import rivp_pkg::*;

  // Elaboration checks: two-word entries need an even start, and the
  // whole table must fit the program address space
  if (BOOT_START[0] != 1'b0)
  begin : g_bad_start
    $error("Boot start must be even");
  end
  if (int'(BOOT_START) + 2 * RIVP_NUM_IRQ > (1 << RIVP_ADDR_W) - 1)
  begin : g_bad_span
    $error("Vector table runs past the address space");
  end
  if (RIVP_NUM_VEC != RIVP_NUM_IRQ + 1)
  begin : g_bad_count
    $error("One reset entry plus one entry per request expected");
  end

  // Vector n at base + words*(n-1)
  function automatic logic [12:0] vec_addr(input logic [4:0] n, input logic [12:0] base);
    logic [12:0] step;
    step = LARGE_VARIANT ? RIVP_WORDS_LARGE : RIVP_WORDS_SMALL;
    vec_addr = 13'(base + 13'(step * 13'(n - 5'h01)));
  endfunction

  rivp_state_t state_q, state_d;
  rivp_fetch_t fetch_d;
  logic        fuse_prog;
  logic [12:0] irq_base;
  logic [4:0]  pick;
  logic        any_req;

  assign fuse_prog = (boot_reset_fuse == RIVP_FUSE_PROG);
  // Table relocation is independent of the fuse
  assign irq_base  = vector_select_bit ? BOOT_START : RIVP_RESET_ADDR;

  always_comb
  begin
    pick    = 5'h00;
    any_req = 1'b0;
    // Downward scan so the lowest number wins
    for (int i = RIVP_NUM_IRQ - 1; i >= 0; i--)
    begin
      if (irq_req[i])
      begin
        pick    = 5'(i + 2);
        any_req = 1'b1;
      end
    end
  end

  always_comb
  begin
    state_d = state_q;
    fetch_d = fetch_q;
    case (state_q)
      RIVP_ST_RESET:
      begin
        // First edge after release hands out the reset entry
        fetch_d.valid   = 1'b1;
        fetch_d.vec_num = 5'h01;
        fetch_d.addr    = fuse_prog ? BOOT_START : RIVP_RESET_ADDR;
        state_d         = RIVP_ST_WAIT;
      end
      RIVP_ST_IDLE:
      begin
        if (any_req)
        begin
          // Relocation applies at dispatch, hence software sets select first
          fetch_d.valid   = 1'b1;
          fetch_d.vec_num = pick;
          fetch_d.addr    = vec_addr(pick, irq_base);
          state_d         = RIVP_ST_WAIT;
        end
      end
      RIVP_ST_WAIT:
      begin
        if (fetch_ack)
        begin
          fetch_d.valid = 1'b0;
          state_d       = RIVP_ST_IDLE;
        end
      end
      default:
      begin
        state_d = RIVP_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= RIVP_ST_RESET;
      fetch_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      fetch_q <= fetch_d;
    end
  end

  property p_reset_entry;
    @(posedge clk) disable iff (!nrst)
    (fetch_q.valid && fetch_q.vec_num == 5'h01) |->
      fetch_q.addr == (boot_reset_fuse ? RIVP_RESET_ADDR : BOOT_START);
  endproperty
  a_reset_entry: assert property (p_reset_entry) else $error("Reset entry wrong");

  // Select is judged as it stood at the dispatch edge
  property p_irq_addr;
    @(posedge clk) disable iff (!nrst)
    ($rose(fetch_q.valid) && fetch_q.vec_num != 5'h01) |->
      fetch_q.addr == 13'(($past(vector_select_bit) ? BOOT_START : 13'h0000) +
        13'((LARGE_VARIANT ? 2 : 1) * (fetch_q.vec_num - 1)));
  endproperty
  a_irq_addr: assert property (p_irq_addr) else $error("Vector address wrong");

  property p_lowest_first;
    @(posedge clk) disable iff (!nrst)
    (state_q == RIVP_ST_IDLE && irq_req[0]) |=> fetch_q.vec_num == 5'h02;
  endproperty
  a_lowest_first: assert property (p_lowest_first) else $error("Priority wrong");

  sequence s_issue;
    state_q == RIVP_ST_IDLE && any_req;
  endsequence
  property p_hold;
    @(posedge clk) disable iff (!nrst)
    s_issue ##1 (!fetch_ack) |=> $stable(fetch_q.addr) && fetch_q.valid;
  endproperty
  a_hold: assert property (p_hold) else $error("Entry dropped before ack");

  property p_fuse_level;
    @(posedge clk) disable iff (!nrst)
    (fetch_q.valid && fetch_q.vec_num == 5'h01 && boot_reset_fuse) |->
      fetch_q.addr == RIVP_RESET_ADDR;
  endproperty
  a_fuse_level: assert property (p_fuse_level) else $error("Fuse sense wrong");

  // Ack is a single pulse; an entry that lingers would be fetched twice
  sequence s_taken;
    fetch_q.valid && fetch_ack;
  endsequence
  property p_ack_drop;
    @(posedge clk) disable iff (!nrst)
    s_taken |=> !fetch_q.valid && state_q == RIVP_ST_IDLE;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("Entry kept after ack");

  // An offered entry stands unchanged until the fetch side takes it
  property p_stands;
    @(posedge clk) disable iff (!nrst)
    (fetch_q.valid && !fetch_ack) |=> fetch_q.valid && $stable(fetch_q);
  endproperty
  a_stands: assert property (p_stands) else $error("Entry changed before ack");

  // A request seen in idle is answered on the very next edge
  property p_answer;
    @(posedge clk) disable iff (!nrst)
    s_issue |=> $rose(fetch_q.valid) && fetch_q.vec_num != 5'h01;
  endproperty
  a_answer: assert property (p_answer) else $error("Request not answered");

  // Whatever follows a reset, vector one comes first
  property p_reset_first;
    @(posedge clk) disable iff (!nrst)
    ($rose(fetch_q.valid) && $past(state_q) == RIVP_ST_RESET) |-> fetch_q.vec_num == 5'h01;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("Reset not first");

  property p_vec_range;
    @(posedge clk) disable iff (!nrst)
    fetch_q.valid |-> fetch_q.vec_num >= 5'h01 && fetch_q.vec_num <= 5'(RIVP_NUM_VEC);
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("Bad vector number");

  // Requests arriving while an entry waits are not latched; the source holds them
  property p_refused;
    @(posedge clk) disable iff (!nrst)
    (state_q == RIVP_ST_WAIT && !fetch_ack) |=>
      state_q == RIVP_ST_WAIT && $stable(fetch_q.vec_num);
  endproperty
  a_refused: assert property (p_refused) else $error("Pending entry displaced");

  // Without select the table stays in the application area
  property p_home_table;
    @(posedge clk) disable iff (!nrst)
    ($rose(fetch_q.valid) && fetch_q.vec_num != 5'h01 && !$past(vector_select_bit)) |->
      fetch_q.addr < 13'((LARGE_VARIANT ? 2 : 1) * RIVP_NUM_VEC);
  endproperty
  a_home_table: assert property (p_home_table) else $error("Table left home");
endmodule

// [verif/rivp_fetch_model.sv]
// Fetch-side model: takes each offered entry after a chosen delay.
// Assumes fetch_q comes from the vector block on clk; drives at falling edge.
`timescale 1ns/1ps
module rivp_fetch_model
  import rivp_pkg::*;
(
  input  wire logic             clk,
  input  rivp_pkg::rivp_fetch_t fetch_q,
  input  wire logic [1:0]       delay,
  output logic                  fetch_ack
);
  logic [1:0] wait_q;
  // One-cycle pulse only; a held ack would swallow the next entry
  initial
  begin
    fetch_ack = 1'b0;
    wait_q    = 2'h0;
    forever
    begin
      @(negedge clk);
      if (fetch_q.valid === 1'b1 && fetch_ack !== 1'b1 && wait_q >= delay)
      begin
        fetch_ack <= 1'b1;
        wait_q    <= 2'h0;
      end
      else if (fetch_q.valid === 1'b1 && fetch_ack !== 1'b1)
      begin
        wait_q <= wait_q + 2'h1;
      end
      else
      begin
        fetch_ack <= 1'b0;
        wait_q    <= 2'h0;
      end
    end
  end
endmodule

// [verif/reset_interrupt_vector_placement_tb.sv]
// Self-checking bench for vector placement, small variant with 2K boot area beside the larger variant with default boot start.
// Assumes the fetch model takes every entry; inputs move at falling edge.
`timescale 1ns/1ps
module reset_interrupt_vector_placement_tb;
  import rivp_pkg::*;
  localparam logic [12:0] BS = 13'h0C00;
  logic        clk = 1'b0, nrst = 1'b0, fuse = 1'b1, sel = 1'b0, ack, ack_large;
  logic [24:0] req = 25'h0000000;
  logic [1:0]  dly = 2'h0;
  rivp_fetch_t fq, fq_large;
  int          err_total = 0, cmp_count = 0, seed;
  rivp_vector #(.LARGE_VARIANT(1'b0), .BOOT_START(BS)) dut (.clk(clk), .nrst(nrst),
    .boot_reset_fuse(fuse), .vector_select_bit(sel), .irq_req(req), .fetch_ack(ack),
    .fetch_q(fq));
  // Larger variant on the same stimulus, default boot start
  rivp_vector dut_large (.clk(clk), .nrst(nrst), .boot_reset_fuse(fuse),
    .vector_select_bit(sel), .irq_req(req), .fetch_ack(ack_large), .fetch_q(fq_large));
  rivp_fetch_model fm (.clk(clk), .fetch_q(fq), .delay(dly), .fetch_ack(ack));
  rivp_fetch_model fm_large (.clk(clk), .fetch_q(fq_large), .delay(dly),
    .fetch_ack(ack_large));
  initial forever #25 clk = ~clk;
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Reset entry first; interrupt entries one word apart, two in the larger variant
  function automatic logic [17:0] exp_of(int n, logic s, logic f, logic lg);
    logic [12:0] bs;
    bs = lg ? RIVP_BOOT_START_DEF : BS;
    if (n == 1)
      return {5'h01, f ? 13'h0000 : bs};
    return {5'(n), (s ? bs : 13'h0000) + 13'((lg ? 2 : 1) * (n - 1))};
  endfunction
  task check(logic [19:0] got, logic [19:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function int low_vec(logic [24:0] r);
    for (int b = 0; b < 25; b++)
      if (r[b])
        return b + 2;
    return 0;
  endfunction
  // Bounded wait on the small variant's ack; a lost entry there ends the run
  task take(int n);
    int i;
    @(posedge clk);
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk);
    check({ack, fq}, {2'b11, exp_of(n, sel, fuse, 1'b0)});
    check({ack_large, fq_large}, {2'b11, exp_of(n, sel, fuse, 1'b1)});
    if (ack !== 1'b1)
      print_verdict();
    else
    begin
      @(negedge clk);
      check({18'h00000, fq.valid, fq_large.valid}, 20'h00000);
    end
  endtask
  initial
  begin
    seed = $urandom(36783);
    for (int k = 0; k < 4; k++)
    begin
      nrst = 1'b0;
      req = 25'h0000000;
      fuse = k[1];
      sel = k[0]; // Set while no request is raised
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      take(1);
      for (int n = 2; n <= 26; n++)
      begin
        req = 25'h0000001 << (n - 2);
        dly <= 2'($urandom);
        take(n);
      end
      req = 25'h1FFFFFF;
      dly <= 2'h3;
      take(2);
      repeat (8)
      begin
        req = 25'($urandom) | 25'h1000000;
        dly <= 2'($urandom);
        take(low_vec(req));
      end
    end
    print_verdict();
  end
endmodule
